/* File: devctl_pkg.sv */
// Constants and size decoding for the device control register block
package devctl_pkg;

  // ***************************************************************
  // Register placement
  // ***************************************************************
  localparam logic [11:0] DEVCTL_OFFSET      = 12'h098; // Dword address
  localparam logic [15:0] DEVCTL_RESET       = 16'h2800;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int RETRY_BIT     = 15;  // config_retry_enable
  localparam int RRS_LSB       = 12;  // read_request_size_limit [14:12]
  localparam int NO_SNOOP_BIT  = 11;  // no_snoop_select
  localparam int AUX_BIT       = 10;  // aux_power_enable
  localparam int PHANTOM_BIT   = 9;   // phantom_function_enable, fixed 0
  localparam int EXT_TAG_BIT   = 8;   // extended_tag_enable, fixed 0
  localparam int PAYLOAD_LSB   = 5;   // payload_size_limit [7:5]
  localparam int RELAX_BIT     = 4;   // relaxed_ordering_enable, fixed 0
  localparam int UR_BIT        = 3;   // unsupported_request_report_enable
  localparam int FATAL_BIT     = 2;   // fatal_report_enable
  localparam int NONFATAL_BIT  = 1;   // nonfatal_report_enable
  localparam int COR_BIT       = 0;   // correctable_report_enable

  // Bits that software may change; all others read fixed values
  localparam logic [15:0] WRITABLE_MASK = 16'hFCEF;

  // ***************************************************************
  // Reset values of the fields
  // ***************************************************************
  localparam logic [2:0] RRS_RESET     = 3'h2;   // 512 bytes
  localparam logic [2:0] PAYLOAD_RESET = 3'h0;   // 128 bytes
  localparam logic       AUX_RESET     = 1'b0;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS  = 8;
  localparam int CFG_TIMEOUT_NS = 50000;  // Forwarded config time-out
  // Longest time rounds down to whole cycles
  localparam int CFG_TIMEOUT_CYCLES = CFG_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // ***************************************************************
  // Size decoding
  // ***************************************************************
  localparam int BYTES_W = 13;
  localparam logic [BYTES_W-1:0] MIN_SIZE_BYTES = 13'h0080;

  // Size code to bytes; reserved codes fall back to the smallest size
  function automatic logic [BYTES_W-1:0] code_to_bytes(
    input logic [2:0] code
  );
    if (code > 3'h5)
      code_to_bytes = MIN_SIZE_BYTES;
    else
      code_to_bytes = MIN_SIZE_BYTES << code;
  endfunction : code_to_bytes

endpackage : devctl_pkg

/* File: prefetch_sizer.sv */
// Prefetch length from read request limit and cache line size
module prefetch_sizer
(
  input  wire logic [2:0]                        i_rrs_code,
  input  wire logic [7:0]                        i_cache_line_dw,
  output logic      [devctl_pkg::BYTES_W-1:0]    o_prefetch_bytes
);

  logic [devctl_pkg::BYTES_W-1:0] limit_bytes; // Read request limit
  logic [devctl_pkg::BYTES_W-1:0] line_bytes;  // Cache line in bytes

  // ***************************************************************
  // Prefetch choice
  // ***************************************************************
  // A line size of zero means unknown, so fetch the full limit;
  // otherwise fetch one line, never past the programmed limit
  always_comb
  begin
    limit_bytes = devctl_pkg::code_to_bytes(i_rrs_code);
    line_bytes  = {3'h0, i_cache_line_dw, 2'h0};
    if (line_bytes == 13'h0000)
      o_prefetch_bytes = limit_bytes;
    else if (line_bytes < limit_bytes)
      o_prefetch_bytes = line_bytes;
    else
      o_prefetch_bytes = limit_bytes;
  end

endmodule : prefetch_sizer

/* File: pcie_bridge_device_control.sv */
// Device control register of the bridge and the logic it steers
module pcie_bridge_device_control
#(
  parameter int CFG_TIMEOUT_CYCLES = devctl_pkg::CFG_TIMEOUT_CYCLES
)
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_aux_rst,
  // Configuration access port, dword addressed
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [11:0] i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // Forwarded configuration transactions
  input  wire logic        i_fwd_cfg_start,
  input  wire logic        i_fwd_cfg_done,
  output logic             o_retry_cpl,
  // Read prefetch
  input  wire logic [7:0]  i_cache_line_dw,
  output logic      [12:0] o_prefetch_bytes,
  // Upstream memory header attribute
  input  wire logic        i_up_mem_valid,
  input  wire logic        i_up_vc_nonzero,
  output logic             o_up_no_snoop,
  // Outgoing payload check
  input  wire logic        i_tx_start,
  input  wire logic [12:0] i_tx_bytes,
  output logic             o_tx_grant,
  output logic             o_tx_reject,
  // Error events and messages
  input  wire logic        i_ur_event,
  input  wire logic        i_fatal_event,
  input  wire logic        i_nonfatal_event,
  input  wire logic        i_cor_event,
  output logic             o_msg_fatal,
  output logic             o_msg_nonfatal,
  output logic             o_msg_cor,
  // Register contents for the rest of the bridge
  output logic      [15:0] o_device_control
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic                    retry_en;      // config_retry_enable
    logic [2:0]              rrs;           // read_request_size_limit
    logic                    no_snoop;      // no_snoop_select
    logic [2:0]              payload;       // payload_size_limit
    logic                    ur_en;         // UR reporting
    logic                    fatal_en;      // Fatal reporting
    logic                    nonfatal_en;   // Nonfatal reporting
    logic                    cor_en;        // Correctable reporting
    logic                    fwd_busy;      // Forwarded config open
    logic [devctl_pkg::TIMER_W-1:0] timer;  // Cycles waited so far
    logic [31:0]             rdata;
    logic                    rvalid;
    logic                    retry_cpl;
    logic [12:0]             prefetch;
    logic                    up_no_snoop;
    logic                    tx_grant;
    logic                    tx_reject;
    logic                    msg_fatal;
    logic                    msg_nonfatal;
    logic                    msg_cor;
  } state_t;

  state_t      state_reg;       // Registered state
  state_t      state_next;      // Next state
  logic        aux_reg;         // aux_power_enable, sticky
  logic        aux_next;
  logic        hit_wr;          // Write to this register
  logic [15:0] wr_mask;         // Byte lanes written and writable
  logic [15:0] cur_value;       // Current register image
  logic [15:0] new_value;       // Image after the write
  logic [12:0] prefetch_comb;   // From the sizer
  logic [12:0] payload_bytes;   // Decoded payload limit

  // ***************************************************************
  // Register image
  // ***************************************************************
  // Read-only feature bits are simply never stored, so they read 0
  // Rebuilt every cycle from the stored fields, so a read and the
  // exported image can never disagree
  always_comb
  begin
    cur_value = 16'h0000;
    cur_value[devctl_pkg::RETRY_BIT] = state_reg.retry_en;
    cur_value[devctl_pkg::RRS_LSB +: 3] = state_reg.rrs;
    cur_value[devctl_pkg::NO_SNOOP_BIT] = state_reg.no_snoop;
    cur_value[devctl_pkg::AUX_BIT] = aux_reg;
    cur_value[devctl_pkg::PHANTOM_BIT] = 1'b0;
    cur_value[devctl_pkg::EXT_TAG_BIT] = 1'b0;
    cur_value[devctl_pkg::RELAX_BIT] = 1'b0;
    cur_value[devctl_pkg::PAYLOAD_LSB +: 3] = state_reg.payload;
    cur_value[devctl_pkg::UR_BIT] = state_reg.ur_en;
    cur_value[devctl_pkg::FATAL_BIT] = state_reg.fatal_en;
    cur_value[devctl_pkg::NONFATAL_BIT] = state_reg.nonfatal_en;
    cur_value[devctl_pkg::COR_BIT] = state_reg.cor_en;
  end

  // ***************************************************************
  // Write merge
  // ***************************************************************
  // Only the low two byte lanes hold this register; the upper half
  // of the dword belongs to the status register and is not ours
  // A write and a read in one cycle both see the old image
  always_comb
  begin
    hit_wr  = i_cfg_wr && (i_cfg_addr == devctl_pkg::DEVCTL_OFFSET);
    wr_mask = {{8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
    wr_mask = wr_mask & devctl_pkg::WRITABLE_MASK;
    new_value = (cur_value & ~wr_mask) | (i_cfg_wdata[15:0] & wr_mask);
    payload_bytes = devctl_pkg::code_to_bytes(state_reg.payload);
  end

  // ***************************************************************
  // Prefetch length
  // ***************************************************************
  // The sizer is purely combinational; its result is registered below
  // prefetch sizing
  prefetch_sizer u_prefetch_sizer
  (
    .i_rrs_code       (state_reg.rrs),
    .i_cache_line_dw  (i_cache_line_dw),
    .o_prefetch_bytes (prefetch_comb)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  // One process computes the next value of every flop but aux_reg; the fields, the
  // time-out counter and all registered outputs share one struct,
  // so a single reset branch covers them all
  always_comb
  begin
    state_next = state_reg;

    // Fields take the merged image on a write
    if (hit_wr)
    begin
      state_next.retry_en = new_value[devctl_pkg::RETRY_BIT];
      state_next.rrs = new_value[devctl_pkg::RRS_LSB +: 3];
      state_next.no_snoop = new_value[devctl_pkg::NO_SNOOP_BIT];
      state_next.payload = new_value[devctl_pkg::PAYLOAD_LSB +: 3];
      state_next.ur_en = new_value[devctl_pkg::UR_BIT];
      state_next.fatal_en = new_value[devctl_pkg::FATAL_BIT];
      state_next.nonfatal_en = new_value[devctl_pkg::NONFATAL_BIT];
      state_next.cor_en = new_value[devctl_pkg::COR_BIT];
    end

    // Read answer one cycle after the strobe; other offsets get zero
    // Every read strobe is answered, so no requester waits forever
    state_next.rvalid = i_cfg_rd;
    if (i_cfg_rd && (i_cfg_addr == devctl_pkg::DEVCTL_OFFSET))
      state_next.rdata = {16'h0000, cur_value};
    else
      state_next.rdata = 32'h0000_0000;

    // Forwarded configuration time-out
    // The counter is TIMER_W bits wide, so the time-out must stay
    // below two to the TIMER_W; a done pulse in the same cycle as a
    // new start is lost, as the start takes priority
    state_next.retry_cpl = 1'b0;
    if (i_fwd_cfg_start)
    begin
      // New transaction restarts the wait
      state_next.fwd_busy = 1'b1;
      state_next.timer    = '0;
    end
    else if (state_reg.fwd_busy)
    begin
      if (i_fwd_cfg_done)
        state_next.fwd_busy = 1'b0;
      else if (32'(state_reg.timer) >= 32'(CFG_TIMEOUT_CYCLES - 1))
      begin
        // Time-out ends the wait whether or not a retry is sent
        state_next.fwd_busy = 1'b0;
        state_next.retry_cpl = state_reg.retry_en;
      end
      else
        state_next.timer = state_reg.timer + 1'b1;
    end

    // Prefetch length registered so the output comes from a flop
    state_next.prefetch = prefetch_comb;

    // Zero for VC0 traffic and whenever no header is being built,
    // so the attribute never leaks onto unrelated requests
    // no-snoop attribute
    state_next.up_no_snoop = i_up_mem_valid && i_up_vc_nonzero &&
                             state_reg.no_snoop;

    // Reserved size codes decode to the smallest size, so a bad
    // setting can only shrink transfers, never let one grow too big
    // payload limit check
    state_next.tx_grant  = i_tx_start && (i_tx_bytes <= payload_bytes);
    state_next.tx_reject = i_tx_start && (i_tx_bytes > payload_bytes);

    // Each event pulse gives at most one message pulse
    // fatal gating
    state_next.msg_fatal = i_fatal_event && state_reg.fatal_en;
    state_next.msg_nonfatal = (i_nonfatal_event && state_reg.nonfatal_en)
                              || (i_ur_event && state_reg.ur_en);
    state_next.msg_cor = i_cor_event && state_reg.cor_en;
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Bridge reset loads the default image; the sticky aux bit is
  // held in its own flop below and is not touched here
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg          <= '0;
      state_reg.retry_en <= 1'b0;
      state_reg.rrs      <= devctl_pkg::RRS_RESET;
      state_reg.no_snoop <= 1'b1;
      state_reg.payload  <= devctl_pkg::PAYLOAD_RESET;
      state_reg.ur_en       <= 1'b0;
      state_reg.fatal_en    <= 1'b0;
      state_reg.nonfatal_en <= 1'b0;
      state_reg.cor_en      <= 1'b0;
    end
    else
      state_reg <= state_next;
  end

  // ***************************************************************
  // Sticky aux power bit
  // ***************************************************************
  // Lives outside the main state because only the aux power-on reset
  // may clear it; the ordinary bridge reset must leave it alone
  // Only the upper byte lane reaches it, like the other high bits
  always_comb
  begin
    aux_next = aux_reg;
    if (hit_wr && i_cfg_be[1])
      aux_next = i_cfg_wdata[devctl_pkg::AUX_BIT];
  end

  always_ff @(posedge i_sys_clk or posedge i_aux_rst)
  begin
    if (i_aux_rst)
      aux_reg <= devctl_pkg::AUX_RESET;
    else
      aux_reg <= aux_next;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // All straight from flip-flops; the image is rebuilt from flops
  assign o_cfg_rdata      = state_reg.rdata;
  assign o_cfg_rvalid     = state_reg.rvalid;
  assign o_retry_cpl      = state_reg.retry_cpl;
  assign o_prefetch_bytes = state_reg.prefetch;
  assign o_up_no_snoop    = state_reg.up_no_snoop;
  assign o_tx_grant       = state_reg.tx_grant;
  assign o_tx_reject      = state_reg.tx_reject;
  assign o_msg_fatal      = state_reg.msg_fatal;
  assign o_msg_nonfatal   = state_reg.msg_nonfatal;
  assign o_msg_cor        = state_reg.msg_cor;
  assign o_device_control = cur_value;

endmodule : pcie_bridge_device_control

/* File: devctl_assertions.sv */
// Port-level checker for the device control register block
module devctl_assertions
#(
  parameter int CFG_TIMEOUT_CYCLES = 20
)
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_cfg_rd,
  input wire logic        i_fwd_cfg_start,
  input wire logic [7:0]  i_cache_line_dw,
  input wire logic        i_up_mem_valid,
  input wire logic        i_up_vc_nonzero,
  input wire logic        i_tx_start,
  input wire logic [12:0] i_tx_bytes,
  input wire logic        i_ur_event,
  input wire logic        i_fatal_event,
  input wire logic        i_nonfatal_event,
  input wire logic        i_cor_event,
  input wire logic        o_cfg_rvalid,
  input wire logic        o_retry_cpl,
  input wire logic [12:0] o_prefetch_bytes,
  input wire logic        o_up_no_snoop,
  input wire logic        o_tx_grant,
  input wire logic        o_tx_reject,
  input wire logic        o_msg_fatal,
  input wire logic        o_msg_nonfatal,
  input wire logic        o_msg_cor,
  input wire logic [15:0] o_device_control
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clock and reset are given once
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // ***************************************************************
  // Register port and fixed bits
  // ***************************************************************
  read_answer_a: assert property (i_cfg_rd |=> o_cfg_rvalid)
    else $error("read not answered next cycle");
  fixed_zero_a: assert property (o_device_control[9:8] == 2'h0 &&
    !o_device_control[4]) else $error("fixed bits not zero");
  reset_image_a: assert property ($fell(i_rst) |->
    (o_device_control & 16'hFBFF) == 16'h2800)
    else $error("reset image wrong");

  // ***************************************************************
  // Retry completions
  // ***************************************************************
  retry_enabled_a: assert property (o_retry_cpl |->
    $past(o_device_control[15])) else $error("retry while disabled");
  retry_late_a: assert property (o_retry_cpl |->
    $past(i_fwd_cfg_start, CFG_TIMEOUT_CYCLES + 1))
    else $error("retry at wrong time");
  retry_early_a: assert property (i_fwd_cfg_start |=>
    !o_retry_cpl [*8]) else $error("retry too early");

  // ***************************************************************
  // Error messages, payload limit, header attribute, prefetch
  // ***************************************************************
  fatal_gate_a: assert property (o_msg_fatal |->
    $past(i_fatal_event && o_device_control[2]))
    else $error("fatal message not enabled");
  nonfatal_gate_a: assert property (o_msg_nonfatal |->
    $past((i_nonfatal_event && o_device_control[1]) ||
          (i_ur_event && o_device_control[3])))
    else $error("nonfatal message not enabled");
  cor_send_a: assert property (i_cor_event && o_device_control[0]
    |=> o_msg_cor) else $error("correctable message missing");
  payload_limit_a: assert property (i_tx_start |=>
    o_tx_grant != o_tx_reject && o_tx_grant == ($past(i_tx_bytes) <=
    (($past(o_device_control[7:5]) > 3'h5) ? 13'h0080 :
    13'h0080 << $past(o_device_control[7:5]))))
    else $error("payload check wrong");
  no_snoop_copy_a: assert property (i_up_mem_valid && i_up_vc_nonzero
    |=> o_up_no_snoop == $past(o_device_control[11]))
    else $error("no-snoop attribute wrong");
  prefetch_full_a: assert property (i_cache_line_dw == 8'h00 &&
    $stable(o_device_control) |=> o_prefetch_bytes ==
    (($past(o_device_control[14:12]) > 3'h5) ? 13'h0080 :
    13'h0080 << $past(o_device_control[14:12])))
    else $error("prefetch length wrong");
endmodule : devctl_assertions

bind pcie_bridge_device_control devctl_assertions
  #(.CFG_TIMEOUT_CYCLES(CFG_TIMEOUT_CYCLES)) u_chk (.i_sys_clk, .i_rst,
  .i_cfg_rd, .i_fwd_cfg_start, .i_cache_line_dw, .i_up_mem_valid,
  .i_up_vc_nonzero, .i_tx_start, .i_tx_bytes, .i_ur_event, .i_fatal_event,
  .i_nonfatal_event, .i_cor_event, .o_cfg_rvalid, .o_retry_cpl,
  .o_prefetch_bytes, .o_up_no_snoop, .o_tx_grant, .o_tx_reject,
  .o_msg_fatal, .o_msg_nonfatal, .o_msg_cor, .o_device_control);

/* File: root_complex_model.sv */
// Upstream partner that counts error messages and retry completions
module root_complex_model
(
  input  wire logic i_sys_clk,
  input  wire logic i_msg_fatal,
  input  wire logic i_msg_nonfatal,
  input  wire logic i_msg_cor,
  input  wire logic i_retry_cpl,
  output int        o_n_fatal,
  output int        o_n_nonfatal,
  output int        o_n_cor,
  output int        o_n_retry
);
  timeunit 1ns;
  timeprecision 1ps;
  // Counts survive bridge reset, as the far side is not reset with it
  initial {o_n_fatal, o_n_nonfatal, o_n_cor, o_n_retry} = '0;
  always @(posedge i_sys_clk)
  begin
    o_n_fatal    += int'(i_msg_fatal === 1'b1);
    o_n_nonfatal += int'(i_msg_nonfatal === 1'b1);
    o_n_cor      += int'(i_msg_cor === 1'b1);
    o_n_retry    += int'(i_retry_cpl === 1'b1);
  end
endmodule : root_complex_model

/* File: pcie_bridge_device_control_tb.sv */
// Self-checking bench for the device control register block
module pcie_bridge_device_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, aux_rst, wr, rd, fs, fd, upv, upvc, txs, rv, ry, ns;
  logic gr, rj, mf, mn, mc;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  evt;   // ur, fatal, nonfatal, cor
  logic [3:0]  be;    // Byte lanes of a write
  logic [12:0] txb, pf;
  logic [7:0]  cl;
  logic [15:0] dc;
  int fails, checks_done, nf, nn, nc, nr;
  integer seed;
  logic [31:0] rd_q[$];  // Expected read data
  logic tx_q[$];         // Expected grant
  logic [31:0] v;

  pcie_bridge_device_control #(.CFG_TIMEOUT_CYCLES(20)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_aux_rst(aux_rst), .i_cfg_wr(wr),
    .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_be(be),
    .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .o_cfg_rvalid(rv),
    .i_fwd_cfg_start(fs), .i_fwd_cfg_done(fd), .o_retry_cpl(ry),
    .i_cache_line_dw(cl), .o_prefetch_bytes(pf), .i_up_mem_valid(upv),
    .i_up_vc_nonzero(upvc), .o_up_no_snoop(ns), .i_tx_start(txs),
    .i_tx_bytes(txb), .o_tx_grant(gr), .o_tx_reject(rj),
    .i_ur_event(evt[3]), .i_fatal_event(evt[2]),
    .i_nonfatal_event(evt[1]), .i_cor_event(evt[0]), .o_msg_fatal(mf),
    .o_msg_nonfatal(mn), .o_msg_cor(mc), .o_device_control(dc));
  root_complex_model u_rc (.i_sys_clk(clk), .i_msg_fatal(mf),
    .i_msg_nonfatal(mn), .i_msg_cor(mc), .i_retry_cpl(ry),
    .o_n_fatal(nf), .o_n_nonfatal(nn), .o_n_cor(nc), .o_n_retry(nr));

  // ***************************************************************
  // Compare tasks and closing
  // ***************************************************************
  task automatic bad(input string m);
    fails++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) bad($sformatf("rdata %h exp %h", g, e));
  endtask : cmp_rd
  task automatic cmp_tx(input logic g, input logic e);
    checks_done++;
    if (g !== e) bad("tx answer");
  endtask : cmp_tx
  task automatic cmp_cnt(input int g, input int e);
    checks_done++;
    if (g != e) bad($sformatf("count %0d exp %0d", g, e));
  endtask : cmp_cnt
  task automatic cmp_ns(input logic g, input logic e);
    checks_done++;
    if (g !== e) bad("no-snoop attribute");
  endtask : cmp_ns
  task automatic cmp_pf(input logic [12:0] g, input logic [12:0] e);
    checks_done++;
    if (g !== e) bad($sformatf("prefetch %0d exp %0d", g, e));
  endtask : cmp_pf
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // ***************************************************************
  // Drivers: every change lands by NBA on the rising edge
  // ***************************************************************
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= {16'hFFFF, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    rd_q.push_back({16'h0000, e});
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_chk
  task automatic pulse(input logic [3:0] e, input logic s);
    @(posedge clk);
    evt <= e; fs <= s;
    @(posedge clk);
    evt <= 4'h0; fs <= 1'b0;
  endtask : pulse
  task automatic tx(input logic [12:0] b, input logic e);
    @(posedge clk);
    txs <= 1'b1; txb <= b;
    tx_q.push_back(e);
  endtask : tx

  // Monitor takes the oldest note whenever a result shows
  always @(posedge clk)
  begin
    if (rv === 1'b1)
      cmp_rd(rdata, (rd_q.size() > 0) ? rd_q.pop_front() : 'x);
    if (gr === 1'b1 || rj === 1'b1)
      cmp_tx(gr, (tx_q.size() > 0) ? tx_q.pop_front() : 1'bx);
  end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    report_and_stop();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    {rst, aux_rst, wr, rd, fs, fd, upv, upvc, txs} = 9'h180;
    {evt, addr, wdata, txb, cl} = '0;
    be = 4'h3;
    seed = 32'h9B43A42A;
    repeat (16) @(posedge clk);
    {rst, aux_rst} <= 2'h0;
    rd_chk(12'h098, 16'h2800);
    wr_reg(12'h098, 16'hFFFF);
    rd_chk(12'h098, 16'hFCEF);
    rd_chk(12'h09C, 16'h0000);
    // Random images, reserved size codes included
    repeat (4)
    begin
      v = $random(seed);
      wr_reg(12'h098, v[15:0]);
      rd_chk(12'h098, v[15:0] & 16'hFCEF);
    end
    // Upper byte lane alone leaves the lower byte untouched
    wr_reg(12'h098, 16'h0000);
    be <= 4'h2;
    wr_reg(12'h098, 16'hFFFF);
    be <= 4'h3;
    rd_chk(12'h098, 16'hFC00);
    // Events with every report enable clear send nothing, then with all four set, then with only UR set
    wr_reg(12'h098, 16'h0000);
    for (int k = 0; k < 4; k++) pulse(4'h1 << k, 1'b0);
    wr_reg(12'h098, 16'h000F);
    for (int k = 0; k < 4; k++) pulse(4'h1 << k, 1'b0);
    wr_reg(12'h098, 16'h0008);
    pulse(4'h8, 1'b0);
    pulse(4'h2, 1'b0);
    repeat (2) @(posedge clk);
    cmp_cnt(nf, 1);
    cmp_cnt(nn, 3);
    cmp_cnt(nc, 1);
    // Payload limit 256 bytes: exact limit, then one byte over
    wr_reg(12'h098, 16'h0020);
    tx(13'h0080 << 1, 1'b1);
    tx((13'h0080 << 1) + 13'h0001, 1'b0);
    @(posedge clk) txs <= 1'b0;
    // Forwarded config that never finishes, retry on then off
    wr_reg(12'h098, 16'h8000);
    pulse(4'h0, 1'b1);
    repeat (30) @(posedge clk);
    cmp_cnt(nr, 1);
    wr_reg(12'h098, 16'h0000);
    pulse(4'h0, 1'b1);
    repeat (30) @(posedge clk);
    cmp_cnt(nr, 1);
    // A forwarded config that finishes in time never retries
    wr_reg(12'h098, 16'h8000);
    pulse(4'h0, 1'b1);
    @(posedge clk) fd <= 1'b1;
    @(posedge clk) fd <= 1'b0;
    repeat (30) @(posedge clk);
    cmp_cnt(nr, 1);
    // No-snoop copy for both values, prefetch with a short line
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(12'h098, k[0] ? 16'h0800 : 16'h0000);
      @(posedge clk) {upv, upvc, cl} <= {2'h3, 8'h10};
      @(posedge clk) {upv, upvc, cl} <= 10'h000;
      @(posedge clk);
      cmp_ns(ns, k[0]);
      cmp_pf(pf, 13'h0040);
    end
    // Aux power bit survives a bridge reset
    wr_reg(12'h098, 16'h0400);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(12'h098, 16'h2C00);
    repeat (3) @(posedge clk);
    cmp_cnt(rd_q.size() + tx_q.size(), 0);
    report_and_stop();
  end
endmodule : pcie_bridge_device_control_tb
